/* logic/sgd_pkg.sv */
package sgd_pkg;

    // register offsets on the serial-port register space
    localparam logic [5:0]  REG_SLIP_CTRL     = 6'h1C;
    localparam logic [5:0]  REG_RESERVED      = 6'h1D;
    localparam logic [5:0]  REG_THERMAL_CTRL  = 6'h1E;

    localparam int          REG_W             = 24;
    localparam int          ADDR_W            = 6;

    // field positions in cycle_slip_prevention_ctrl, plus the enable bit of the thermal control word
    localparam int          STEP_LSB          = 0;
    localparam int          STEP_MSB          = 3;
    localparam int          RSTB_FORCE_BIT    = 4;
    localparam int          RSTB_BIT          = 5;
    localparam int          THERM_EN_BIT      = 0;

    // reset values
    localparam logic [23:0] SLIP_CTRL_RST     = 24'h000020;
    localparam logic [23:0] RESERVED_RST      = 24'h000000;
    localparam logic [23:0] THERMAL_RST       = 24'h000000;

    // detector reset pulse length after a slip event, in cycles
    localparam logic [1:0]  AUTO_RST_CYCLES   = 2'h2;

    typedef struct packed {
        logic              we;
        logic              re;
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  wdata;
    } sgd_reg_req_t;

    typedef struct packed {
        logic       valid;
        logic       retard;
        logic [2:0] cycles;
    } sgd_step_t;

endpackage : sgd_pkg

/* logic/sgd_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser for asynchronous levels
module sgd_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // elaboration check: a zero-width synchroniser has nothing to carry
    if (WIDTH < 1) begin : g_bad_width
        $error("sgd_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : sgd_sync

/* logic/sgd_slip_guard.sv */
`timescale 1ns/1ps
module sgd_slip_guard (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    input  wire sgd_pkg::sgd_reg_req_t reg_req,
    output logic [sgd_pkg::REG_W-1:0] reg_rdata,
    output logic                      reg_rvalid,
    input  wire logic                 slip_guard_global_en,
    input  wire logic                 ref_clk_in,
    input  wire logic                 vco_div_clk_in,
    output logic                      cp_up,
    output logic                      cp_dn,
    output logic                      cp_hiz,
    output logic                      pfd_rst_n,
    output sgd_pkg::sgd_step_t        slip_step,
    output logic                      thermal_en
);

    logic                      rst_meta_r;
    logic                      rst_n;
    logic [sgd_pkg::REG_W-1:0] slip_ctrl_r;
    logic [sgd_pkg::REG_W-1:0] reserved_r;
    logic [sgd_pkg::REG_W-1:0] thermal_r;
    logic [1:0]                clk_sync;
    logic [1:0]                clk_prev_r;
    logic                      ref_edge;
    logic                      vco_edge;
    logic                      up_r;
    logic                      dn_r;
    logic [1:0]                auto_rst_cnt_r;
    logic                      slip_event;
    logic                      guard_on;
    logic                      pfd_in_reset;
    logic [3:0]                slip_step_count;
    logic [1:0]                clk_edge;

    // elaboration checks on the step field width and the automatic reset pulse length the logic relies on
    if (sgd_pkg::STEP_MSB - sgd_pkg::STEP_LSB != 3) begin : g_bad_step
        $error("slip step field must be four bits wide");
    end
    if (sgd_pkg::AUTO_RST_CYCLES == 2'h0) begin : g_bad_pulse
        $error("automatic detector reset needs at least one cycle");
    end

    // one address decode for the write and read paths, one-hot by register
    function automatic logic [2:0] reg_select(input logic [sgd_pkg::ADDR_W-1:0] addr);
        logic [2:0] sel;
        sel    = 3'h0;
        sel[0] = (addr == sgd_pkg::REG_SLIP_CTRL);
        sel[1] = (addr == sgd_pkg::REG_RESERVED);
        sel[2] = (addr == sgd_pkg::REG_THERMAL_CTRL);
        return sel;
    endfunction : reg_select

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // pins from the reference and divider clock domains
    sgd_sync #(
        .WIDTH (2)
    ) u_clk_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in ({vco_div_clk_in, ref_clk_in}),
        .sync_out (clk_sync)
    );

    // register writes; all bits kept so readback matches
    // package reset values (slip control 24'h000020, others zero) and readback
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            slip_ctrl_r <= sgd_pkg::SLIP_CTRL_RST;
            reserved_r  <= sgd_pkg::RESERVED_RST;
            thermal_r   <= sgd_pkg::THERMAL_RST;
        end else if (reg_req.we) begin
            case (reg_select(reg_req.addr))
                3'h1:    slip_ctrl_r <= reg_req.wdata;
                3'h2:    reserved_r  <= reg_req.wdata;
                3'h4:    thermal_r   <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // registered readback, unmapped offsets read zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.re;
            if (reg_req.re) begin
                case (reg_select(reg_req.addr))
                    3'h1:    reg_rdata <= slip_ctrl_r;
                    3'h2:    reg_rdata <= reserved_r;
                    3'h4:    reg_rdata <= thermal_r;
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

    // step field straight from the control word
    assign slip_step_count = slip_ctrl_r[sgd_pkg::STEP_MSB:sgd_pkg::STEP_LSB];

    // rising-edge detect on each synchronised clock, index 0 reference
    for (genvar k = 0; k < 2; k++) begin : g_edge
        assign clk_edge[k] = clk_sync[k] & ~clk_prev_r[k];
    end
    assign ref_edge = clk_edge[0];
    assign vco_edge = clk_edge[1];

    // override hands the reset to software, so stepping is held off then
    // zero step disables
    // automatic control only with override low
    assign guard_on = (slip_step_count != 4'h0)
                    & slip_ctrl_r[sgd_pkg::RSTB_BIT]
                    & ~slip_ctrl_r[sgd_pkg::RSTB_FORCE_BIT]
                    & slip_guard_global_en;

    // a second edge on a side already leading means a full cycle of error
    // full-cycle detection
    assign slip_event = guard_on & ((ref_edge & ~vco_edge & up_r)
                                  | (vco_edge & ~ref_edge & dn_r));

    assign pfd_in_reset = slip_ctrl_r[sgd_pkg::RSTB_FORCE_BIT]
                        ? ~slip_ctrl_r[sgd_pkg::RSTB_BIT]
                        : (auto_rst_cnt_r != 2'h0);

    // edge history for the synchronised clocks
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev_r <= 2'h0;
        end else begin
            clk_prev_r <= clk_sync;
        end
    end

    // automatic detector reset, a short pulse after each slip
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_rst_cnt_r <= 2'h0;
        end else if (slip_event) begin
            auto_rst_cnt_r <= sgd_pkg::AUTO_RST_CYCLES;
        end else if (auto_rst_cnt_r != 2'h0) begin
            auto_rst_cnt_r <= auto_rst_cnt_r - 2'h1;
        end
    end

    // tri-state detector: up/down flops, cleared together or by reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_r <= 1'b0;
            dn_r <= 1'b0;
        end else if (pfd_in_reset || slip_event) begin
            up_r <= 1'b0;
            dn_r <= 1'b0;
        end else begin
            // both pending means aligned: clear, as a real detector does
            up_r <= (up_r | ref_edge) & ~(dn_r | vco_edge);
            dn_r <= (dn_r | vco_edge) & ~(up_r | ref_edge);
        end
    end

    // step command to the divider, one-cycle pulse
    // polarity from top bit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            slip_step <= '0;
        end else begin
            slip_step.valid  <= slip_event;
            slip_step.retard <= slip_step_count[3];
            slip_step.cycles <= slip_step_count[2:0];
        end
    end

    // charge pump drive, high impedance while detector in reset
    // registered so the pump sees no glitch when the reset source flips
    // tristate in reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cp_up     <= 1'b0;
            cp_dn     <= 1'b0;
            cp_hiz    <= 1'b1;
            pfd_rst_n <= 1'b0;
        end else begin
            cp_up     <= up_r & ~pfd_in_reset;
            cp_dn     <= dn_r & ~pfd_in_reset;
            cp_hiz    <= pfd_in_reset;
            pfd_rst_n <= ~pfd_in_reset;
        end
    end

    // sensor enable tap; the rest of that word is only stored
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            thermal_en <= 1'b0;
        end else begin
            thermal_en <= thermal_r[sgd_pkg::THERM_EN_BIT];
        end
    end

endmodule : sgd_slip_guard

/* verification/sgd_slip_guard_monitor.sv */
`timescale 1ns/1ps
module sgd_slip_guard_monitor (
    input wire logic                      sys_clk,
    input wire logic                      rst_b,
    input wire sgd_pkg::sgd_reg_req_t     reg_req,
    input wire logic [sgd_pkg::REG_W-1:0] reg_rdata,
    input wire logic                      reg_rvalid,
    input wire logic                      slip_guard_global_en,
    input wire logic                      cp_hiz,
    input wire logic                      pfd_rst_n,
    input wire sgd_pkg::sgd_step_t        slip_step
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // write then read of the spare word
    sequence spare_wr_rd;
        reg_req.we && reg_req.addr == sgd_pkg::REG_RESERVED ##1
            reg_req.re && !reg_req.we && reg_req.addr == sgd_pkg::REG_RESERVED;
    endsequence
    // detector held two cycles, then let go
    sequence auto_pulse;
        !pfd_rst_n [*2] ##1 pfd_rst_n;
    endsequence
    chk_hiz_follows_rst: assert property (cp_hiz == !pfd_rst_n)
        else $error("pump not tristated in detector reset");
    chk_read_answer: assert property (reg_req.re |=> reg_rvalid)
        else $error("read not answered");
    chk_spare_readback: assert property (spare_wr_rd |=> reg_rdata == $past(reg_req.wdata, 2))
        else $error("spare word readback wrong");
    chk_step_nonzero: assert property (slip_step.valid |-> {slip_step.retard, slip_step.cycles} != 4'h0)
        else $error("step issued with zero count");
    chk_step_global: assert property (slip_step.valid |-> $past(slip_guard_global_en))
        else $error("step without global enable");
    chk_step_single: assert property (slip_step.valid |=> !slip_step.valid)
        else $error("step pulse too long");
    chk_auto_pulse: assert property (slip_step.valid |=> auto_pulse)
        else $error("automatic detector reset wrong");
    chk_manual_rst: assert property (reg_req.we && reg_req.addr == sgd_pkg::REG_SLIP_CTRL
        && reg_req.wdata[4] |-> ##2 pfd_rst_n == $past(reg_req.wdata[5], 2))
        else $error("manual detector reset ignored");
endmodule : sgd_slip_guard_monitor

bind sgd_slip_guard sgd_slip_guard_monitor i_sgd_slip_guard_monitor (.sys_clk, .rst_b,
    .reg_req, .reg_rdata, .reg_rvalid, .slip_guard_global_en, .cp_hiz, .pfd_rst_n, .slip_step);

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
    logic                  sys_clk = 1'b0, rst_b = 1'b0, gen = 1'b0, ref_in = 1'b0;
    logic                  vco_in = 1'b0, seen, up_seen, dn_seen;
    sgd_pkg::sgd_reg_req_t reg_req = '0;
    logic                  reg_rvalid, cp_up, cp_dn, cp_hiz, pfd_rst_n, thermal_en;
    logic [23:0]           reg_rdata, d;
    sgd_pkg::sgd_step_t    slip_step, got;
    int                    bad_count = 0, compares = 0;

    sgd_slip_guard i_sgd_slip_guard (.sys_clk, .rst_b, .reg_req, .reg_rdata, .reg_rvalid,
        .slip_guard_global_en(gen), .ref_clk_in(ref_in), .vco_div_clk_in(vco_in),
        .cp_up, .cp_dn, .cp_hiz, .pfd_rst_n, .slip_step, .thermal_en);

    // free-running system clock
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [23:0] g, input logic [23:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check
    task automatic close_out();
        if (bad_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    task automatic wr(input logic [5:0] a, input logic [23:0] v);
        @(posedge sys_clk);
        reg_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: v};
        @(posedge sys_clk);
        reg_req <= '0;
    endtask : wr
    // answer stands one cycle only, so look at the middle of it
    task automatic rd(input logic [5:0] a);
        @(posedge sys_clk);
        reg_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 24'h000000};
        @(posedge sys_clk);
        reg_req <= '0;
        @(negedge sys_clk);
        d = (reg_rvalid === 1'b1) ? reg_rdata : 24'hXXXXXX;
    endtask : rd
    task automatic t_reset_values();
        rd(6'h1C); check(d, 24'h000020);
        rd(6'h1D); check(d, 24'h000000);
        rd(6'h3F); check(d, 24'h000000);
        check({22'h0, cp_hiz, pfd_rst_n}, 24'h000001);
    endtask : t_reset_values
    task automatic t_readback();
        wr(6'h1D, 24'hA5A5A5);
        rd(6'h1D); check(d, 24'hA5A5A5);
        wr(6'h1E, 24'h000001);
        rd(6'h1E); check(d, 24'h000001);
        check({23'h0, thermal_en}, 24'h000001);
        // write and read back to back: the read sees the new word
        @(posedge sys_clk);
        reg_req <= '{we: 1'b1, re: 1'b0, addr: 6'h1D, wdata: 24'h5A5A5A};
        @(posedge sys_clk);
        reg_req <= '{we: 1'b0, re: 1'b1, addr: 6'h1D, wdata: 24'h000000};
        @(posedge sys_clk);
        reg_req <= '0;
        @(negedge sys_clk);
        check((reg_rvalid === 1'b1) ? reg_rdata : 24'hXXXXXX, 24'h5A5A5A);
    endtask : t_readback
    // manual hold must tristate the pump until released
    task automatic t_manual(input logic [23:0] v, input logic [1:0] e);
        wr(6'h1C, v);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        check({20'h0, cp_up, cp_dn, cp_hiz, pfd_rst_n}, {20'h0, 2'b00, e});
    endtask : t_manual
    // ref runs while divided vco stands still, so the error passes a full cycle
    task automatic t_slip(input logic [23:0] v, input logic g, input logic on);
        wr(6'h1C, v);
        gen <= g;
        seen = 1'b0;
        got = '0;
        up_seen = 1'b0;
        dn_seen = 1'b0;
        for (int i = 0; i < 64 && !seen; i++) begin
            @(posedge sys_clk);
            ref_in <= i[2];
            @(negedge sys_clk);
            up_seen |= (cp_up === 1'b1);
            dn_seen |= (cp_dn === 1'b1);
            if (slip_step.valid === 1'b1) begin
                seen = 1'b1;
                got = slip_step;
            end
        end
        @(posedge sys_clk);
        ref_in <= 1'b0;
        check({19'h0, seen, got.retard, got.cycles}, {19'h0, on, on ? v[3:0] : 4'h0});
        check({22'h0, up_seen, dn_seen}, 24'h000002);
        if (on && !seen) close_out();
    endtask : t_slip
    // main sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_reset_values();
        t_readback();
        t_manual(24'h000010, 2'b10);
        t_manual(24'h000030, 2'b01);
        // override kept low in the normal stepping runs
        t_slip(24'h000020, 1'b1, 1'b0);
        t_slip(24'h000023, 1'b1, 1'b1);
        t_slip(24'h00002B, 1'b1, 1'b1);
        t_slip(24'h000028, 1'b1, 1'b1);
        t_slip(24'h00000B, 1'b1, 1'b0);
        t_slip(24'h000027, 1'b0, 1'b0);
        t_slip(24'h000037, 1'b1, 1'b0);
        close_out();
    end
    // hang guard
    initial begin
        #500000;
        bad_count++;
        close_out();
    end
endmodule : tb
